// ---- hdl/sar_adc_serial_readout.sv ----
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module sar_adc_serial_readout
    import sar_pkg::*;
#(
    parameter int RES_W    = `SAR_RES_W,
    parameter int CONV_CYC = `SAR_CONV_CYC,
    parameter int DLY_CYC  = `SAR_START_DLY_CYC,
    parameter int HALF_CYC = `SAR_BIT_HALF_CYC
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               ce,
    input  wire sar_axi_req_s       axi_req,
    output sar_axi_rsp_s            axi_rsp,
    input  wire logic               chip_select_n,
    input  wire logic               read_convert_n,
    input  wire logic               serial_bit_clock_i,
    output logic                    serial_bit_clock_o,
    output logic                    serial_bit_clock_oe,
    input  wire logic               cascade_input,
    input  wire logic [RES_W-1:0]   sar_result,
    output logic                    serial_data,
    output logic                    frame_pulse,
    output logic                    busy_n
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    // the burst must finish inside one conversion and counters are 8 bit
    if (RES_W != `SAR_RES_W || CONV_CYC < 2 || CONV_CYC > 255 ||
        DLY_CYC < 1 || HALF_CYC < 1 ||
        DLY_CYC + 2 * HALF_CYC * RES_W >= CONV_CYC) begin : g_bad_cfg
        $error("sar_adc_serial_readout: unsupported parameters");
    end

    localparam logic [`SAR_CNT_W-1:0] CONV_C = `SAR_CNT_W'(CONV_CYC);
    localparam logic [`SAR_CNT_W-1:0] DLY_C  = `SAR_CNT_W'(DLY_CYC);
    localparam logic [`SAR_CNT_W-1:0] HALF_C = `SAR_CNT_W'(HALF_CYC);
    localparam logic [4:0]            LAST_B = 5'(RES_W - 1);

    sar_state_s st_reg;
    sar_state_s st_next;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pin_s;
    logic       cs_s;
    logic       rc_s;
    logic       clk_s;
    logic       tag_s;

    sar_sync #(
        .W (4)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .din     ({chip_select_n, read_convert_n, serial_bit_clock_i, cascade_input}),
        .dout    (pin_s)
    );

    assign cs_s  = pin_s[3];
    assign rc_s  = pin_s[2];
    assign clk_s = pin_s[1];
    assign tag_s = pin_s[0];

    // ------------------------------------------------------------------
    // output format
    // ------------------------------------------------------------------
    // core result is straight binary; twos complement flips the MSB
    function automatic logic [RES_W-1:0] sar_fmt(input logic [RES_W-1:0] x,
                                                 input logic             sb);
        sar_fmt = sb ? x : {~x[RES_W-1], x[RES_W-2:0]};
    endfunction : sar_fmt

    // ------------------------------------------------------------------
    // strobe and clock events
    // ------------------------------------------------------------------
    logic strobe_or;
    logic strobe_or_prev;
    logic conv_start;
    logic ext_enter;
    logic ext_leave;
    logic clk_rise;

    // strobes are ORed; conversion begins on the later falling edge
    assign strobe_or      = cs_s | rc_s;
    assign strobe_or_prev = st_reg.cs_prev | st_reg.rc_prev;
    assign conv_start     = strobe_or_prev & ~strobe_or & st_reg.busy_n;
    // read entry: rc rises with cs low, or cs falls with rc high
    assign ext_enter = st_reg.clk_src & ~cs_s & rc_s &
                       (~st_reg.rc_prev | st_reg.cs_prev);
    assign ext_leave = cs_s | ~rc_s;
    assign clk_rise  = clk_s & ~st_reg.clk_prev;

    // ------------------------------------------------------------------
    // axi4-lite decode helpers
    // ------------------------------------------------------------------
    logic aw_hs;
    logic w_hs;
    logic ar_hs;

    assign aw_hs = axi_req.awvalid & st_reg.rsp.awready;
    assign w_hs  = axi_req.wvalid & st_reg.rsp.wready;
    assign ar_hs = axi_req.arvalid & st_reg.rsp.arready;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0]             rword;
        logic [1:0]              rresp;
        logic [`SAR_ADDR_W-1:0]  waddr;
        logic [1:0]              wbits;
        logic                    wlane0;
        rword  = 32'h0;
        rresp  = `SAR_RESP_OKAY;
        waddr  = st_reg.waddr;
        wbits  = st_reg.wbits;
        wlane0 = st_reg.wlane0;
        st_next = st_reg;

        // register write: address and data in either order
        if (aw_hs) begin
            waddr = axi_req.awaddr;
            st_next.aw_got = 1'b1;
        end
        if (w_hs) begin
            wbits  = axi_req.wdata[1:0];
            wlane0 = axi_req.wstrb[0];
            st_next.w_got = 1'b1;
        end
        st_next.waddr  = waddr;
        st_next.wbits  = wbits;
        st_next.wlane0 = wlane0;
        if (st_next.aw_got && st_next.w_got && !st_reg.rsp.bvalid) begin
            st_next.aw_got    = 1'b0;
            st_next.w_got     = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp  = `SAR_RESP_OKAY;
            if (waddr == `SAR_CTRL_OFS) begin
                if (wlane0) begin
                    st_next.clk_src = wbits[`SAR_CTRL_SRC_BIT];
                    st_next.fmt     = wbits[`SAR_CTRL_FMT_BIT];
                end
            end else if (waddr != `SAR_STAT_OFS && waddr != `SAR_RESULT_OFS) begin
                st_next.rsp.bresp = `SAR_RESP_DECERR;
            end
        end else if (st_reg.rsp.bvalid && axi_req.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end

        // register read, answered the edge after the address is taken
        case (axi_req.araddr)
            `SAR_CTRL_OFS: begin
                rword[`SAR_CTRL_SRC_BIT] = st_reg.clk_src;
                rword[`SAR_CTRL_FMT_BIT] = st_reg.fmt;
            end
            `SAR_STAT_OFS: begin
                rword[`SAR_STAT_BUSY_BIT]  = st_reg.busy_n;
                rword[`SAR_STAT_VALID_BIT] = st_reg.nconv[1];
                rword[`SAR_STAT_READ_BIT]  = (st_reg.rd != SAR_RD_IDLE);
                rword[`SAR_STAT_ARMED_BIT] = st_reg.edge_seen;
            end
            `SAR_RESULT_OFS: begin
                rword[RES_W-1:0] = st_reg.stored;
            end
            default: begin
                rresp = `SAR_RESP_DECERR;
            end
        endcase
        if (ar_hs) begin
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rdata  = rword;
            st_next.rsp.rresp  = rresp;
        end else if (st_reg.rsp.rvalid && axi_req.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end

        // strobe history for edge detection
        st_next.cs_prev  = cs_s;
        st_next.rc_prev  = rc_s;
        st_next.clk_prev = clk_s;

        // conversion: busy low while it runs, result stored at the end
        if (conv_start) begin
            st_next.busy_n   = 1'b0;
            st_next.conv_cnt = CONV_C;
        end else if (!st_reg.busy_n) begin
            if (st_reg.conv_cnt == `SAR_CNT_W'(1)) begin
                st_next.stored = sar_result;
                st_next.busy_n = 1'b1;
                if (!st_reg.nconv[1]) begin
                    st_next.nconv = st_reg.nconv + 2'h1;
                end
            end
            st_next.conv_cnt = st_reg.conv_cnt - `SAR_CNT_W'(1);
        end

        // a rising edge seen outside the read state arms a frame pulse
        if (st_reg.clk_src && clk_rise && st_reg.rd != SAR_RD_EXT) begin
            st_next.edge_seen = 1'b1;
        end

        // readout sequencer
        case (st_reg.rd)
            SAR_RD_IDLE: begin
                st_next.sclk_out = 1'b0;
                if (!st_reg.clk_src && conv_start) begin
                    // previous result, tag level parked behind the LSB
                    st_next.shreg  = {sar_fmt(st_reg.stored, st_reg.fmt), tag_s};
                    st_next.sdata  = sar_fmt(st_reg.stored, st_reg.fmt) >> (RES_W - 1) != 0;
                    st_next.cnt    = DLY_C;
                    st_next.bitcnt = 5'h0;
                    st_next.rd     = SAR_RD_DELAY;
                end else if (ext_enter) begin
                    st_next.shreg      = {sar_fmt(st_reg.stored, st_reg.fmt), tag_s};
                    st_next.sdata      = sar_fmt(st_reg.stored, st_reg.fmt) >> (RES_W - 1) != 0;
                    st_next.frame_pend = st_reg.edge_seen;
                    st_next.edge_seen  = 1'b0;
                    st_next.presented  = 1'b0;
                    st_next.frame      = 1'b0;
                    st_next.rd         = SAR_RD_EXT;
                end
            end
            SAR_RD_DELAY: begin
                // hold off the burst until clock_start_delay has passed
                if (st_reg.cnt == `SAR_CNT_W'(1)) begin
                    st_next.sclk_out = 1'b1;
                    st_next.cnt      = HALF_C;
                    st_next.rd       = SAR_RD_HIGH;
                end else begin
                    st_next.cnt = st_reg.cnt - `SAR_CNT_W'(1);
                end
            end
            SAR_RD_HIGH: begin
                if (st_reg.cnt == `SAR_CNT_W'(1)) begin
                    st_next.sclk_out = 1'b0;
                    st_next.cnt      = HALF_C;
                    st_next.rd       = SAR_RD_LOW;
                end else begin
                    st_next.cnt = st_reg.cnt - `SAR_CNT_W'(1);
                end
            end
            SAR_RD_LOW: begin
                // data moves only after the falling edge of its pulse
                if (st_reg.cnt == `SAR_CNT_W'(1)) begin
                    st_next.shreg  = {st_reg.shreg[RES_W-1:0], tag_s};
                    st_next.sdata  = st_reg.shreg[RES_W-1];
                    st_next.bitcnt = st_reg.bitcnt + 5'h1;
                    if (st_reg.bitcnt == LAST_B) begin
                        st_next.rd = SAR_RD_IDLE;
                    end else begin
                        st_next.sclk_out = 1'b1;
                        st_next.cnt      = HALF_C;
                        st_next.rd       = SAR_RD_HIGH;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt - `SAR_CNT_W'(1);
                end
            end
            SAR_RD_EXT: begin
                // data changes on rising edges so it spans fall then rise
                if (ext_leave) begin
                    st_next.frame = 1'b0;
                    st_next.rd    = SAR_RD_IDLE;
                end else if (clk_rise) begin
                    if (st_reg.frame_pend) begin
                        st_next.frame      = 1'b1;
                        st_next.frame_pend = 1'b0;
                    end else if (!st_reg.presented) begin
                        st_next.frame     = 1'b0;
                        st_next.presented = 1'b1;
                    end else begin
                        // upstream bits follow the LSB down the chain
                        st_next.shreg = {st_reg.shreg[RES_W-1:0], tag_s};
                        st_next.sdata = st_reg.shreg[RES_W-1];
                        st_next.frame = 1'b0;
                    end
                end
            end
            default: begin
                st_next.rd = SAR_RD_IDLE;
            end
        endcase

        // pin direction follows the clock source select
        st_next.sclk_oe = ~st_next.clk_src;
        if (st_next.clk_src) begin
            st_next.sclk_out = 1'b0;
        end

        // ready flags are registered; one transfer of each kind at a time
        st_next.rsp.awready = ~st_next.aw_got & ~st_next.rsp.bvalid;
        st_next.rsp.wready  = ~st_next.w_got & ~st_next.rsp.bvalid;
        st_next.rsp.arready = ~st_next.rsp.rvalid;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg         <= '0;
            st_reg.clk_src <= `SAR_CTRL_SRC_RST;
            st_reg.fmt     <= `SAR_CTRL_FMT_RST;
            st_reg.cs_prev <= 1'b0; // sync chain also starts at zero,
            st_reg.rc_prev <= 1'b0; // so release shows no false strobe fall
            st_reg.busy_n  <= 1'b1;
            st_reg.sclk_oe <= 1'b1;
            st_reg.rd      <= SAR_RD_IDLE;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------
    assign axi_rsp             = st_reg.rsp;
    assign serial_bit_clock_o  = st_reg.sclk_out;
    assign serial_bit_clock_oe = st_reg.sclk_oe;
    assign serial_data         = st_reg.sdata;
    assign frame_pulse         = st_reg.frame;
    assign busy_n              = st_reg.busy_n;

endmodule : sar_adc_serial_readout

// ---- hdl/sar_cfg.svh ----
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define SAR_CLK_PERIOD_NS 100
// conversion time of the internal converter core
`define SAR_CONV_TIME_NS 8000
`define SAR_CONV_CYC ((`SAR_CONV_TIME_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
// clock_start_delay before the internal burst
`define SAR_START_DLY_NS 200
`define SAR_START_DLY_CYC ((`SAR_START_DLY_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
// half period of the internally made serial_bit_clock
`define SAR_BIT_HALF_NS 200
`define SAR_BIT_HALF_CYC ((`SAR_BIT_HALF_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define SAR_RES_W  16
`define SAR_ADDR_W 8
`define SAR_CNT_W  8

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SAR_CTRL_OFS   8'h00
`define SAR_STAT_OFS   8'h04
`define SAR_RESULT_OFS 8'h08
`define SAR_CTRL_SRC_BIT   0
`define SAR_CTRL_FMT_BIT   1
`define SAR_CTRL_SRC_RST   1'h0
`define SAR_CTRL_FMT_RST   1'h1
`define SAR_STAT_BUSY_BIT  0
`define SAR_STAT_VALID_BIT 1
`define SAR_STAT_READ_BIT  2
`define SAR_STAT_ARMED_BIT 3
`define SAR_RESP_OKAY   2'h0
`define SAR_RESP_DECERR 2'h3

`endif

// ---- hdl/sar_pkg.sv ----
package sar_pkg;
`include "sar_cfg.svh"

    // ------------------------------------------------------------------
    // readout sequencer, gray along idle-delay-high-low
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SAR_RD_IDLE  = 3'h0,
        SAR_RD_DELAY = 3'h1,
        SAR_RD_HIGH  = 3'h3,
        SAR_RD_LOW   = 3'h2,
        SAR_RD_EXT   = 3'h6
    } sar_rd_e;

    // ------------------------------------------------------------------
    // axi4-lite carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                   awvalid;
        logic [`SAR_ADDR_W-1:0] awaddr;
        logic                   wvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bready;
        logic                   arvalid;
        logic [`SAR_ADDR_W-1:0] araddr;
        logic                   rready;
    } sar_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sar_axi_rsp_s;

    // ------------------------------------------------------------------
    // whole state of the readout block
    // ------------------------------------------------------------------
    typedef struct packed {
        sar_axi_rsp_s           rsp;
        logic                   aw_got;
        logic                   w_got;
        logic [`SAR_ADDR_W-1:0] waddr;
        logic [1:0]             wbits;
        logic                   wlane0;
        logic                   clk_src;
        logic                   fmt;
        logic                   cs_prev;
        logic                   rc_prev;
        logic                   clk_prev;
        logic                   busy_n;
        logic [`SAR_CNT_W-1:0]  conv_cnt;
        logic [`SAR_RES_W-1:0]  stored;
        logic [1:0]             nconv;
        sar_rd_e                rd;
        logic [`SAR_CNT_W-1:0]  cnt;
        logic [4:0]             bitcnt;
        logic [`SAR_RES_W:0]    shreg;
        logic                   edge_seen;
        logic                   frame_pend;
        logic                   presented;
        logic                   sdata;
        logic                   frame;
        logic                   sclk_out;
        logic                   sclk_oe;
    } sar_state_s;

endpackage : sar_pkg

// ---- hdl/sar_sync.sv ----
`timescale 1ns/1ps

// two-flop synchroniser for pins from outside the aclk domain
module sar_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    // stage 0 is read only by stage 1
    logic [1:0][W-1:0] st_reg;
    logic [1:0][W-1:0] st_next;

    // ------------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------------
    always_comb begin
        st_next    = st_reg;
        st_next[0] = din;
        st_next[1] = st_reg[0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg[1];
endmodule : sar_sync

// ---- verification/sar_host_model.sv ----
`timescale 1ns/1ps
module sar_host_model (
    input  wire logic aclk,
    input  wire logic serial_data,
    input  wire logic frame_pulse,
    output logic      chip_select_n,
    output logic      read_convert_n,
    output logic      serial_bit_clock
);
    // strobes idle high, bit clock stands low outside frames
    initial begin
        chip_select_n = 1'b1;
        read_convert_n = 1'b1;
        serial_bit_clock = 1'b0;
    end
    task sel(input logic v);
        chip_select_n <= v;
    endtask : sel
    // held six cycles so the pin synchronisers see it
    task convert();
        read_convert_n <= 1'b0;
        repeat (6) @(posedge aclk);
        read_convert_n <= 1'b1;
    endtask : convert
    // 800 ns period, sampled mid-low where the bit has settled
    task pulses(input int n, output logic [17:0] d, output logic [17:0] f);
        d = 18'h0;
        f = 18'h0;
        repeat (n) begin
            serial_bit_clock <= 1'b1;
            repeat (4) @(posedge aclk);
            serial_bit_clock <= 1'b0;
            repeat (2) @(posedge aclk);
            d = {d[16:0], serial_data};
            f = {f[16:0], frame_pulse};
            repeat (2) @(posedge aclk);
        end
    endtask : pulses
endmodule : sar_host_model

// ---- verification/sar_readout_checker.sv ----
`timescale 1ns/1ps
module sar_readout_checker #(
    parameter int CONV_CYC = 80
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_select_n,
    input wire logic read_convert_n,
    input wire logic serial_bit_clock_o,
    input wire logic serial_bit_clock_oe,
    input wire logic serial_data,
    input wire logic frame_pulse,
    input wire logic busy_n
);
    logic [7:0] low_reg;
    logic [7:0] pls_reg;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // busy-low length and burst pulses of each conversion
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        low_reg <= (!aresetn || busy_n) ? 8'h00 : low_reg + 8'h01;
        pls_reg <= (!aresetn || $fell(busy_n)) ? 8'h00 : pls_reg + 8'($rose(serial_bit_clock_o));
    end
    AST_BUSY_LEN: assert property ($rose(busy_n) |-> low_reg == CONV_CYC)
        else $error("busy low length off");
    AST_START: assert property (busy_n && $fell(chip_select_n | read_convert_n) |-> ##[2:4] !busy_n)
        else $error("no conversion start");
    AST_SCLK_SHAPE: assert property ($rose(serial_bit_clock_o) |-> serial_bit_clock_o[*2] ##1 !serial_bit_clock_o[*2])
        else $error("bit clock shape");
    AST_BURST_IN_CONV: assert property (serial_bit_clock_o |-> !busy_n && serial_bit_clock_oe)
        else $error("bit clock outside conversion");
    AST_BURST_COUNT: assert property ($rose(busy_n) && serial_bit_clock_oe |-> pls_reg == 8'h10)
        else $error("burst pulse count");
    AST_BURST_DELAY: assert property ($fell(busy_n) && serial_bit_clock_oe |-> !serial_bit_clock_o[*2] ##[1:2] serial_bit_clock_o)
        else $error("burst start delay");
    AST_DATA_HOLD: assert property ($rose(serial_bit_clock_o) |-> ##1 $stable(serial_data)[*3])
        else $error("data moved inside bit");
    AST_FRAME_EXT: assert property (frame_pulse |-> !serial_bit_clock_oe)
        else $error("marker in internal mode");
    AST_FRAME_SLOT: assert property ($rose(frame_pulse) |-> frame_pulse[*4] ##[1:8] !frame_pulse)
        else $error("marker slot length");
    COV_INT: cover property ($rose(busy_n) && serial_bit_clock_oe);
    COV_EXT: cover property ($rose(busy_n) && !serial_bit_clock_oe);
    COV_FRAME: cover property ($rose(frame_pulse));
endmodule : sar_readout_checker

bind sar_adc_serial_readout sar_readout_checker #(.CONV_CYC(CONV_CYC)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .chip_select_n(chip_select_n), .read_convert_n(read_convert_n), .serial_bit_clock_o(serial_bit_clock_o),
    .serial_bit_clock_oe(serial_bit_clock_oe), .serial_data(serial_data), .frame_pulse(frame_pulse),
    .busy_n(busy_n));

// ---- verification/tb_sar_adc_serial_readout.sv ----
`timescale 1ns/1ps
module tb_sar_adc_serial_readout;
    import sar_pkg::*;
    logic         aclk, aresetn, cascade_input, sclk_o, sclk_oe, sclk_q, sdata, frame, busy_n, cs_n, rc_n, sclk_h;
    logic [15:0]  result, burst;
    sar_axi_req_s req;
    sar_axi_rsp_s rsp;
    int           err_total, checks, cyc;
    sar_adc_serial_readout dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .axi_req(req), .axi_rsp(rsp),
        .chip_select_n(cs_n), .read_convert_n(rc_n), .serial_bit_clock_i(sclk_h), .serial_bit_clock_o(sclk_o),
        .serial_bit_clock_oe(sclk_oe), .cascade_input(cascade_input), .sar_result(result), .serial_data(sdata),
        .frame_pulse(frame), .busy_n(busy_n));
    sar_host_model host (.aclk(aclk), .serial_data(sdata), .frame_pulse(frame), .chip_select_n(cs_n),
        .read_convert_n(rc_n), .serial_bit_clock(sclk_h));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // capture the internal burst on each bit clock rise; also the hang guard
    always @(posedge aclk) begin
        sclk_q <= sclk_o;
        if (sclk_o && !sclk_q) burst <= {burst[14:0], sdata};
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            complete_run();
        end
    end
    task cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task axi_wr(input logic [7:0] a, input logic [31:0] dt);
        {req.awaddr, req.wdata, req.wstrb} <= {a, dt, 4'hF};
        {req.awvalid, req.wvalid, req.bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        cmp(rsp.bresp, 32'h0);
        @(posedge aclk);
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] rs);
        {req.araddr, req.arvalid, req.rready} <= {a, 2'h3};
        forever begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        req.rready <= 1'b0;
        cmp(rsp.rdata & m, e);
        cmp(rsp.rresp, rs);
        @(posedge aclk);
    endtask : axi_rd
    // one conversion; burst holds the earlier result, data then rests at cascade level
    task conv(input logic [15:0] nxt, input logic [15:0] e, input logic on, input logic oe);
        result <= nxt;
        host.sel(1'b0);
        host.convert();
        cmp(busy_n, 32'h0);
        forever begin
            @(posedge aclk);
            if (busy_n === 1'b1) break;
        end
        cmp(busy_n, 32'h1);
        cmp(sclk_oe, oe);
        if (on) cmp(burst, e);
        if (oe) cmp(sdata, cascade_input);
    endtask : conv
    // external read during sampling, finished before the next conversion
    task rd_ext(input logic arm, input logic cas, input logic [15:0] e);
        logic [17:0] d, f;
        cascade_input <= cas;
        host.sel(1'b1);
        repeat (4) @(posedge aclk);
        if (arm) host.pulses(1, d, f);
        host.sel(1'b0);
        repeat (4) @(posedge aclk);
        host.pulses(arm ? 18 : 17, d, f);
        cmp(d[16:0], {e, cas});
        cmp(f[16:0], 32'h0);
        if (arm) cmp(f[17], 32'h1);
    endtask : rd_ext
    task complete_run();
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        {aresetn, req, cascade_input, result, err_total, checks} = '0;
        cascade_input = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(8'h00, 32'h2, 32'hFFFFFFFF, 2'h0);
        axi_rd(8'h0C, 32'h0, 32'hFFFFFFFF, 2'h3);
        conv(16'hA5C3, 16'h0, 1'b0, 1'b1);
        axi_rd(8'h04, 32'h1, 32'h3, 2'h0);
        conv(16'h3C96, 16'hA5C3, 1'b1, 1'b1);
        axi_rd(8'h04, 32'h3, 32'h3, 2'h0);
        axi_wr(8'h00, 32'h0);
        conv(16'h1234, 16'hBC96, 1'b1, 1'b1);
        axi_rd(8'h08, 32'h1234, 32'hFFFFFFFF, 2'h0);
        axi_wr(8'h00, 32'h3);
        conv(16'h8001, 16'h0, 1'b0, 1'b0);
        rd_ext(1'b1, 1'b0, 16'h8001);
        rd_ext(1'b0, 1'b1, 16'h8001);
        complete_run();
    end
endmodule : tb_sar_adc_serial_readout
